// [core/fwu_pkg.sv]
`default_nettype none
package fwu_pkg;
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Firmware splits into a fixed boot loader and a replaceable main program.
// R2: The host keeps its own backup copy of the image during updates.
// R3: Flash writes never reach the boot loader area; boot loader always runs.
// R4: No internal backup of the main program is kept.
// R5: Upload mode answers capability, protocol revision and model name reads.
// R6: Query works for any code as block process call with PEC.
// R7: Mode control is a read/write byte; upload status is a read word.
// R8: Image blocks are PEC block writes of the header block size.
// R9: Firmware revision is a three byte block read with PEC.
// R10: Green indicator flashes at two hertz while an update runs.
// R11: New firmware becomes active only when upload mode is left.
// R12: A bad image still leaves a working boot loader in safe mode.
// R13: Safe mode after a bad image still allows entering upload mode.
// R14: Header holds CRC, image info, block size and write time fields.
// R15: Header bytes eleven to twenty-three are a vendor model name area.
// R16: Header byte twenty-four: major version bits 0-6, bit 7 down-revision.
// R17: Bytes 25 and 26 are minor revisions; 27 and 28 compatibility characters.
// R18: Compatibility word: first character in low byte, second in high byte.
// R19: Compatibility value is fixed, changed only with incompatible hardware.
// R20: Capability bit two means upload while on, no power cycle; 3-7 reserved.
// R21: Capability bits zero and one are reserved and read zero.
// R22: Every advertised upload mode can update all firmware.
// R23: Mode bit 0 set enters upload; clear exits unless the image is corrupt.
// R24: Entering upload mode clears the whole status word.
// R25: Status bits: 0 success, 1 not yet received, 2 corrupt image.
// R26: Indicator toggles every 250 ms from the system clock in upload mode.
////////////////////////////////////////////////////////////////////////////////
localparam logic [7:0]  CMD_CAPAB   = 8'h19;
localparam logic [7:0]  CMD_QUERY   = 8'h1a;
localparam logic [7:0]  CMD_PROTO   = 8'h98;
localparam logic [7:0]  CMD_MODEL   = 8'h9a;
localparam logic [7:0]  CMD_COMPAT  = 8'hd4;
localparam logic [7:0]  CMD_UPCAP   = 8'hd5;
localparam logic [7:0]  CMD_MODE    = 8'hd6;
localparam logic [7:0]  CMD_BLOCK   = 8'hd7;
localparam logic [7:0]  CMD_STATUS  = 8'hd8;
localparam logic [7:0]  CMD_REV     = 8'hd9;
localparam logic [7:0]  CAPAB_VAL   = 8'h80;
localparam logic [7:0]  PROTO_VAL   = 8'h22;
localparam logic [7:0]  UPCAP_VAL   = 8'h04;
localparam logic [7:0]  REV_LEN     = 8'h03;
localparam int          MODEL_LEN   = 8;
localparam logic [7:0]  Q_SUP       = 8'h80;
localparam logic [7:0]  Q_WR        = 8'h40;
localparam logic [7:0]  Q_RD        = 8'h20;
localparam int          MODE_BIT    = 0;
localparam int          ST_OK       = 0;
localparam int          ST_WAIT     = 1;
localparam int          ST_BAD      = 2;
localparam logic [15:0] STATUS_RST  = 16'h0000;
localparam logic [15:0] HDR_CRC_LO  = 16'h0000;
localparam logic [15:0] HDR_CRC_HI  = 16'h0001;
localparam logic [15:0] HDR_INFO    = 16'h0002;
localparam logic [15:0] HDR_LEN_HI  = 16'h0003;
localparam logic [15:0] HDR_MAJOR   = 16'h0017;
localparam logic [15:0] HDR_MIN1    = 16'h0018;
localparam logic [15:0] HDR_MIN2    = 16'h0019;
localparam logic [15:0] HDR_BSZ_LO  = 16'h001c;
localparam logic [15:0] HDR_BSZ_HI  = 16'h001d;
localparam logic [15:0] MAIN_BASE   = 16'h1000;
localparam logic [15:0] MAIN_SPAN   = 16'hf000;
localparam logic [7:0]  PEC_POLY    = 8'h07;
localparam logic [15:0] CRC_POLY    = 16'h1021;
localparam logic [15:0] CRC_INIT    = 16'hffff;
localparam int unsigned CLK_HZ      = 250_000_000;
localparam int unsigned BLINK_MS    = 250;
localparam int unsigned BLINK_CYC   = CLK_HZ / 1000 * BLINK_MS;

typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_WR, PH_RD} phase_e;

typedef struct packed {
   logic       start;
   logic       stop;
   logic       wr_valid;
   logic [7:0] wr_byte;
   logic       rd_take;
} link_in_s;

typedef struct packed {
   logic [7:0] rd_byte;
   logic       nack;
} link_out_s;

typedef struct packed {
   logic        we;
   logic [15:0] addr;
   logic [7:0]  data;
} flash_s;

function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
   logic [7:0] r;
   r = c ^ d;
   for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ PEC_POLY) : (r << 1);
   return r;
endfunction

function automatic logic is_cmd(input logic [7:0] c);
   return c inside {CMD_CAPAB, CMD_QUERY, CMD_PROTO, CMD_MODEL, CMD_COMPAT,
                    CMD_UPCAP, CMD_MODE, CMD_BLOCK, CMD_STATUS, CMD_REV};
endfunction

function automatic logic [7:0] query_bits(input logic [7:0] c);
   if (!is_cmd(c)) return 8'h00;
   return Q_SUP | ((c inside {CMD_MODE, CMD_BLOCK, CMD_QUERY}) ? Q_WR : 8'h00)
                | ((c != CMD_BLOCK) ? Q_RD : 8'h00);
endfunction

endpackage
`default_nettype wire

// [core/image_crc16.sv]
`default_nettype none
module image_crc16 (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   input  wire logic [7:0]  data,
   output logic [15:0]      crc
);
   import fwu_pkg::*;
   logic [15:0] crc_r;
   logic [15:0] crc_nxt;

   // Running image checksum with restore point for a refused block.
   always_comb begin
      crc_nxt = crc_r;
      if (clr) begin
         crc_nxt = CRC_INIT;
      end else if (load) begin
         crc_nxt = load_val;
      end else if (en) begin
         crc_nxt = crc_r ^ {data, 8'h00};
         for (int i = 0; i < 8; i++) begin
            crc_nxt = crc_nxt[15] ? ((crc_nxt << 1) ^ CRC_POLY) : (crc_nxt << 1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) crc_r <= CRC_INIT;
      else crc_r <= crc_nxt;
   end

   assign crc = crc_r;
endmodule
`default_nettype wire

// [core/blink_div.sv]
`default_nettype none
module blink_div #(
   parameter int unsigned CYCLES = fwu_pkg::BLINK_CYC
)(
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic en,
   output logic      tick
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        tick_r;
   logic        tick_nxt;

   // One-cycle pulse every CYCLES clocks while enabled.
   always_comb begin
      tick_nxt = 1'b0;
      cnt_nxt  = 32'h0000_0000;
      if (en) begin
         if (cnt_r == CYCLES - 1) tick_nxt = 1'b1;
         else cnt_nxt = cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r  <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule
`default_nettype wire

// [core/fwu_loader.sv]
`default_nettype none
module fwu_loader #(
   parameter int unsigned                     BLINK_CYCLES = fwu_pkg::BLINK_CYC,
   parameter logic [15:0]                     COMPAT_WORD  = 16'h3141,
   parameter logic [8*fwu_pkg::MODEL_LEN-1:0] MODEL_NAME   = "PSU-0001"
)(
   input  wire logic               clk_sys,
   input  wire logic               rstn,
   input  wire fwu_pkg::link_in_s  lin,
   input  wire logic               main_ok,
   output var  fwu_pkg::link_out_s lout,
   output var  fwu_pkg::flash_s    flash,
   output logic                    led_green,
   output logic                    upload_active,
   output logic                    safe_mode,
   output logic                    commit,
   output logic [23:0]             fw_rev
);
   import fwu_pkg::*;

   typedef struct packed {
      phase_e      ph;
      logic [7:0]  cmd;
      logic [15:0] bcnt;
      logic [7:0]  pec;
      logic [7:0]  wb0;
      logic [7:0]  wb1;
      logic        upload;
      logic [15:0] status;
      logic [15:0] img_off;
      logic [15:0] blk_start;
      logic [15:0] crc_save;
      logic [15:0] crc_exp;
      logic [15:0] img_len;
      logic [15:0] blk_size;
      logic [23:0] rev_new;
      logic [23:0] fw_rev;
      logic        commit;
      logic        safe;
      logic        led;
      link_out_s   lo;
      flash_s      fl;
   } state_s;

   state_s          st_r;
   state_s          st_nxt;
   logic [15:0][7:0] rsp;
   logic [3:0]      rlen;
   logic            pec_ok;
   logic            crc_clr;
   logic            crc_en;
   logic            crc_ld;
   logic [15:0]     crc_now;
   logic            tick;
   logic            rd_open;

   image_crc16 u_crc (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clr      (crc_clr),
      .en       (crc_en),
      .load     (crc_ld),
      .load_val (st_r.crc_save),
      .data     (lin.wr_byte),
      .crc      (crc_now)
   );

   blink_div #(.CYCLES(BLINK_CYCLES)) u_blink (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .en      (st_r.upload),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transaction handling, image intake and reply selection.
   always_comb begin
      st_nxt           = st_r;
      st_nxt.commit    = 1'b0;
      st_nxt.fl.we     = 1'b0;
      st_nxt.lo.nack   = 1'b0;
      crc_clr          = 1'b0;
      crc_en           = 1'b0;
      crc_ld           = 1'b0;
      pec_ok           = 1'b0;
      rsp              = '0;
      rlen             = 4'h0;

      if (tick) begin
         st_nxt.led = ~st_r.led; // R10 R26
      end
      if (!st_r.upload) begin
         st_nxt.led = 1'b1;
      end
      st_nxt.safe = st_r.status[ST_BAD] | ~main_ok; // R12

      // Bus events in priority order: start, stop, byte, read take.
      if (lin.start) begin
         if (st_r.ph == PH_IDLE) begin
            st_nxt.pec = 8'h00;
         end
         st_nxt.ph = PH_ADDR;
      end else if (lin.stop) begin
         st_nxt.ph = PH_IDLE;
         if (st_r.ph == PH_WR) begin
            pec_ok = (st_r.pec == 8'h00) && (st_r.bcnt >= 16'h0002);
            if (st_r.cmd == CMD_MODE && pec_ok && st_r.bcnt == 16'h0002) begin // R7
               if (st_r.wb0[MODE_BIT]) begin // R13 R23
                  st_nxt.upload    = 1'b1;
                  st_nxt.status    = STATUS_RST; // R24
                  st_nxt.img_off   = '0;
                  st_nxt.blk_start = '0;
                  st_nxt.img_len   = '0;
                  st_nxt.blk_size  = '0;
                  st_nxt.crc_save  = CRC_INIT;
                  crc_clr          = 1'b1;
               end else if (st_r.upload && !st_r.status[ST_BAD]) begin // R23
                  st_nxt.upload = 1'b0;
                  st_nxt.commit = 1'b1; // R11
                  if (st_r.status[ST_OK]) begin
                     st_nxt.fw_rev = st_r.rev_new;
                  end
               end
            end else if (st_r.cmd == CMD_BLOCK && st_r.upload) begin
               if (pec_ok && st_r.bcnt == {8'h00, st_r.wb0} + 16'h0002
                   && st_r.blk_size == {8'h00, st_r.wb0}) begin // R8
                  st_nxt.blk_start = st_r.img_off;
                  st_nxt.crc_save  = crc_now;
                  if (st_r.img_len != 16'h0000 && st_r.img_off >= st_r.img_len
                      && st_r.status[ST_WAIT]) begin // R25
                     st_nxt.status[ST_WAIT] = 1'b0;
                     st_nxt.status[ST_OK]   = (crc_now == st_r.crc_exp);
                     st_nxt.status[ST_BAD]  = (crc_now != st_r.crc_exp);
                  end
               end else begin
                  st_nxt.img_off = st_r.blk_start; // R8
                  crc_ld         = 1'b1;
                  st_nxt.lo.nack = 1'b1;
               end
            end
         end
      end else if (lin.wr_valid) begin
         st_nxt.pec = crc8_step(st_r.pec, lin.wr_byte);
         unique case (st_r.ph)
            PH_ADDR: begin
               st_nxt.ph   = lin.wr_byte[0] ? PH_RD : PH_CMD;
               st_nxt.bcnt = '0;
            end
            PH_CMD: begin
               st_nxt.cmd     = lin.wr_byte;
               st_nxt.bcnt    = '0;
               st_nxt.ph      = PH_WR;
               st_nxt.lo.nack = !is_cmd(lin.wr_byte)
                                || (lin.wr_byte == CMD_BLOCK && !st_r.upload);
            end
            PH_WR: begin
               st_nxt.bcnt = st_r.bcnt + 16'h0001;
               if (st_r.bcnt == 16'h0000) begin
                  st_nxt.wb0 = lin.wr_byte;
               end
               if (st_r.bcnt == 16'h0001) begin
                  st_nxt.wb1 = lin.wr_byte; // R6
               end
               if (st_r.cmd == CMD_BLOCK && st_r.upload && st_r.bcnt != 16'h0000
                   && st_r.bcnt <= {8'h00, st_r.wb0} && st_r.img_off < MAIN_SPAN) begin
                  st_nxt.fl.we   = 1'b1; // R1 R4
                  st_nxt.fl.addr = MAIN_BASE + st_r.img_off; // R3
                  st_nxt.fl.data = lin.wr_byte;
                  st_nxt.img_off = st_r.img_off + 16'h0001;
                  st_nxt.status[ST_WAIT] = ~st_r.status[ST_OK] & ~st_r.status[ST_BAD]; // R25
                  crc_en = (st_r.img_off >= HDR_INFO);
                  unique case (st_r.img_off) // R14 R15
                     HDR_CRC_LO: st_nxt.crc_exp[7:0]   = lin.wr_byte;
                     HDR_CRC_HI: st_nxt.crc_exp[15:8]  = lin.wr_byte;
                     HDR_INFO:   st_nxt.img_len[7:0]   = lin.wr_byte;
                     HDR_LEN_HI: st_nxt.img_len[15:8]  = lin.wr_byte;
                     HDR_MAJOR:  st_nxt.rev_new[23:16] = lin.wr_byte; // R16
                     HDR_MIN1:   st_nxt.rev_new[15:8]  = lin.wr_byte; // R17
                     HDR_MIN2:   st_nxt.rev_new[7:0]   = lin.wr_byte; // R17
                     HDR_BSZ_LO: st_nxt.blk_size[7:0]  = lin.wr_byte; // R14
                     HDR_BSZ_HI: st_nxt.blk_size[15:8] = lin.wr_byte; // R14
                     default: ;
                  endcase
               end
            end
            PH_IDLE, PH_RD: begin
               st_nxt.lo.nack = 1'b1;
            end
         endcase
      end else if (lin.rd_take && st_r.ph == PH_RD) begin
         st_nxt.pec  = crc8_step(st_r.pec, st_r.lo.rd_byte);
         st_nxt.bcnt = st_r.bcnt + 16'h0001;
      end

      // Reply bytes for the command in hand, followed by the PEC byte.
      unique case (st_nxt.cmd)
         CMD_CAPAB: begin
            rsp[0] = CAPAB_VAL; // R5
            rlen   = 4'h1;
         end
         CMD_PROTO: begin
            rsp[0] = PROTO_VAL; // R5
            rlen   = 4'h1;
         end
         CMD_MODEL: begin
            rsp[0] = 8'(MODEL_LEN); // R5
            for (int k = 0; k < MODEL_LEN; k++) begin
               rsp[k + 1] = MODEL_NAME[8*(MODEL_LEN-1-k) +: 8];
            end
            rlen   = 4'(MODEL_LEN + 1);
         end
         CMD_QUERY: begin
            rsp[0] = 8'h01;
            rsp[1] = query_bits(st_nxt.wb1); // R6
            rlen   = 4'h2;
         end
         CMD_COMPAT: begin
            rsp[0] = COMPAT_WORD[7:0]; // R18 R19
            rsp[1] = COMPAT_WORD[15:8];
            rlen   = 4'h2;
         end
         CMD_UPCAP: begin
            rsp[0] = UPCAP_VAL; // R20 R21 R22
            rlen   = 4'h1;
         end
         CMD_MODE: begin
            rsp[0] = {7'h00, st_nxt.upload}; // R7
            rlen   = 4'h1;
         end
         CMD_STATUS: begin
            rsp[0] = st_nxt.status[7:0]; // R7
            rsp[1] = st_nxt.status[15:8];
            rlen   = 4'h2;
         end
         CMD_REV: begin
            rsp[0] = REV_LEN; // R9
            rsp[1] = st_nxt.fw_rev[7:0];
            rsp[2] = st_nxt.fw_rev[15:8];
            rsp[3] = st_nxt.fw_rev[23:16];
            rlen   = 4'h4;
         end
         default: rlen = 4'h0;
      endcase

      if (st_nxt.bcnt < {12'h000, rlen}) begin
         st_nxt.lo.rd_byte = rsp[st_nxt.bcnt[3:0]];
      end else if (st_nxt.bcnt == {12'h000, rlen}) begin
         st_nxt.lo.rd_byte = st_nxt.pec;
      end else begin
         st_nxt.lo.rd_byte = 8'hff;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lout          = st_r.lo;
   assign flash         = st_r.fl;
   assign led_green     = st_r.led;
   assign upload_active = st_r.upload;
   assign safe_mode     = st_r.safe;
   assign commit        = st_r.commit;
   assign fw_rev        = st_r.fw_rev;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   // Read replies are checked on the address byte that opens the read.
   assign rd_open = lin.wr_valid && !lin.start && !lin.stop && st_r.ph == PH_ADDR
                    && lin.wr_byte[0];

   led_idle_a: assert property ($fell(st_r.upload) |=> st_r.led) // R10
      else $error("Indicator not steady after leaving upload.");

   led_rate_a: assert property ( // R26
      st_r.upload && $past(st_r.upload) && $changed(st_r.led) |-> $past(tick))
      else $error("Indicator toggled without divider pulse.");

   enter_clear_a: assert property ($rose(st_r.upload) |-> st_r.status == 16'h0000) // R24
      else $error("Status not cleared on entering upload.");

   corrupt_stay_a: assert property (st_r.upload && st_r.status[ST_BAD] |=> st_r.upload) // R23
      else $error("Left upload mode with corrupt image.");

   flash_floor_a: assert property ( // R3
      st_r.fl.we |-> st_r.fl.addr >= MAIN_BASE && st_r.upload)
      else $error("Flash write outside main program area.");

   commit_exit_a: assert property (st_r.commit |-> $fell(st_r.upload)) // R11
      else $error("Commit without leaving upload mode.");

   status_excl_a: assert property ( // R25
      !(st_r.status[ST_OK] && (st_r.status[ST_BAD] || st_r.status[ST_WAIT])))
      else $error("Inconsistent upload status.");

   rev_count_a: assert property ( // R9
      rd_open && st_r.cmd == CMD_REV
      |=> lout.rd_byte == REV_LEN)
      else $error("Revision read does not report three bytes.");

   upcap_val_a: assert property ( // R20
      rd_open && st_r.cmd == CMD_UPCAP
      |=> lout.rd_byte == UPCAP_VAL)
      else $error("Upload capability byte wrong.");

   capab_val_a: assert property ( // R5
      rd_open && st_r.cmd == CMD_CAPAB |=> lout.rd_byte == CAPAB_VAL)
      else $error("Capability byte wrong.");

   compat_low_a: assert property ( // R18
      rd_open && st_r.cmd == CMD_COMPAT |=> lout.rd_byte == COMPAT_WORD[7:0])
      else $error("Compatibility low byte wrong.");

   block_nack_a: assert property ( // R8
      lin.wr_valid && !lin.start && !lin.stop && st_r.ph == PH_CMD
      && lin.wr_byte == CMD_BLOCK && !st_r.upload |=> lout.nack)
      else $error("Image block accepted outside upload mode.");

   safe_bad_a: assert property (st_r.status[ST_BAD] |=> st_r.safe) // R12
      else $error("Safe mode missing after corrupt image.");

   commit_rev_a: assert property ( // R11
      st_r.commit && st_r.status[ST_OK] |-> st_r.fw_rev == st_r.rev_new)
      else $error("New revision not taken on commit.");

   busy_flag_a: assert property (st_r.fl.we |-> st_r.status != STATUS_RST) // R25
      else $error("Status idle while image bytes are written.");

   enter_c: cover property ($rose(st_r.upload));
   good_c:  cover property ($rose(st_r.status[ST_OK]));
   bad_c:   cover property ($rose(st_r.status[ST_BAD]));
   commit_c: cover property (st_r.commit);
   refuse_c: cover property (st_r.lo.nack);
endmodule
`default_nettype wire

// [bench/fwu_host.sv]
`default_nettype none
module fwu_host (
   input  wire logic               clk_sys,
   output var  fwu_pkg::link_in_s  lin,
   input  wire fwu_pkg::link_out_s lout
);
   timeunit 1ns;
   timeprecision 1ps;
   import fwu_pkg::*;
   localparam logic [7:0] ADDR_W = 8'hb0;
   logic [7:0] img  [0:63];
   logic [7:0] wbuf [0:40];
   logic [7:0] rbuf [0:40];
   logic [7:0] pec;
   logic       pec_ok;
   logic       nack_seen;
   initial lin = '0;
   initial nack_seen = 1'b0;
   always @(negedge clk_sys) if (lout.nack === 1'b1) nack_seen = 1'b1;
////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] pstep(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
      return r;
   endfunction
   // Drives one link event for one cycle: 0 start, 1 stop, 2 byte, 3 take, else idle.
   task automatic put(input int k, input logic [7:0] b);
      link_in_s v;
      v = '0;
      v.start = (k == 0);
      v.stop = (k == 1);
      v.wr_valid = (k == 2);
      v.wr_byte = b;
      v.rd_take = (k == 3);
      lin = v;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic wb(input logic [7:0] b);
      pec = pstep(pec, b);
      put(2, b);
   endtask
   // One whole transaction; nr = 0 is a write, else a read of nr bytes plus PEC.
   task automatic xfer(input logic [7:0] cmd, input int nw, input int nr, input logic bad);
      nack_seen = 1'b0;
      pec = 8'h00;
      pec_ok = 1'b1;
      put(0, 8'h00);
      wb(ADDR_W);
      wb(cmd);
      for (int i = 0; i < nw; i++) wb(wbuf[i]);
      if (nr == 0) begin
         wb(pec ^ {7'h0, bad});
      end else begin
         put(0, 8'h00);
         wb(ADDR_W | 8'h01);
         for (int i = 0; i <= nr; i++) begin
            rbuf[i] = lout.rd_byte;
            if (i == nr) pec_ok = (lout.rd_byte === pec);
            pec = pstep(pec, lout.rd_byte);
            put(3, 8'h00);
         end
      end
      put(1, 8'h00);
      repeat (3) put(4, 8'h00);
   endtask
   // Builds a 64-byte image of two 32-byte blocks; bad spoils the stored CRC.
   task automatic build(input logic bad);
      logic [15:0] c;
      for (int i = 0; i < 64; i++) img[i] = 8'(i * 7 + 3);
      img[2] = 8'h40;
      img[3] = 8'h00;
      img[23] = 8'h85;
      img[24] = 8'h12;
      img[25] = 8'h34;
      img[26] = 8'h31;
      img[27] = 8'h41;
      img[28] = 8'h20;
      img[29] = 8'h00;
      c = 16'hffff;
      for (int i = 2; i < 64; i++) begin
         c = c ^ {img[i], 8'h00};
         for (int k = 0; k < 8; k++) c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end
      img[0] = c[7:0] ^ {7'h0, bad};
      img[1] = c[15:8];
   endtask
   task automatic send_block(input int blk, input int n, input logic bad);
      wbuf[0] = 8'(n);
      for (int i = 0; i < n; i++) wbuf[i + 1] = img[blk * 32 + i];
      xfer(8'hd7, n + 1, 0, bad);
   endtask
endmodule
`default_nettype wire

// [bench/fwu_loader_tb_top.sv]
`default_nettype none
module fwu_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fwu_pkg::*;
   localparam int BLINK = 8;
   logic        clk_sys;
   logic        rstn;
   logic        main_ok;
   link_in_s    lin;
   link_out_s   lout;
   flash_s      flash;
   logic        led_green;
   logic        upload_active;
   logic        safe_mode;
   logic        commit;
   logic [23:0] fw_rev;
   int          fails;
   int          n_tests;
   int          n_commit;
   int          per;
   fwu_loader #(.BLINK_CYCLES(BLINK)) dut (.clk_sys(clk_sys), .rstn(rstn), .lin(lin),
      .main_ok(main_ok), .lout(lout), .flash(flash), .led_green(led_green),
      .upload_active(upload_active), .safe_mode(safe_mode), .commit(commit), .fw_rev(fw_rev));
   fwu_host host (.clk_sys(clk_sys), .lin(lin), .lout(lout));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] cmd, input int nr, input logic [23:0] exp);
      logic [23:0] got;
      host.xfer(cmd, 0, nr, 1'b0);
      got = {host.rbuf[2], host.rbuf[1], host.rbuf[0]};
      if (nr < 3) got = got & ((24'h1 << (8 * nr)) - 24'h1);
      check("read data", exp, got);
      check("read pec", 24'h1, {23'h0, host.pec_ok});
   endtask
   task automatic wr_mode(input logic [7:0] v);
      host.wbuf[0] = v;
      host.xfer(CMD_MODE, 1, 0, 1'b0);
   endtask
   task automatic blink_period(output int n);
      logic l;
      for (int k = 0; k < 2; k++) begin
         l = led_green;
         n = 0;
         while (led_green === l && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
         end
      end
   endtask
////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk_sys) begin
      if (commit === 1'b1) n_commit++;
      if (flash.we === 1'b1) begin
         check("flash data", {16'h0, host.img[6'(flash.addr - MAIN_BASE)]}, {16'h0, flash.data});
         check("flash area", 24'h1, 24'(flash.addr >= MAIN_BASE));
      end
   end
   initial begin
      repeat (50000) @(posedge clk_sys);
      fails++;
      tally_and_finish();
   end
   initial begin
      logic [7:0] qc [4] = '{8'hd7, 8'hd6, 8'h19, 8'h55};
      logic [7:0] qe [4] = '{8'hc0, 8'he0, 8'ha0, 8'h00};
      rstn = 1'b0;
      main_ok = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 rstn = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      check("led idle", 24'h1, {23'h0, led_green});
      rd(CMD_UPCAP, 1, 24'h04);
      rd(CMD_CAPAB, 1, 24'h80);
      rd(CMD_PROTO, 1, 24'h22);
      rd(CMD_MODEL, 9, 24'h535008);
      rd(CMD_COMPAT, 2, 24'h3141);
      rd(CMD_STATUS, 2, 24'h0000);
      rd(CMD_MODE, 1, 24'h00);
      rd(CMD_REV, 4, 24'h000003);
      $display("test identification done");
      for (int i = 0; i < 4; i++) begin
         host.wbuf[0] = 8'h01;
         host.wbuf[1] = qc[i];
         host.xfer(CMD_QUERY, 2, 2, 1'b0);
         check("query", {8'h0, qe[i], 8'h01}, {8'h0, host.rbuf[1], host.rbuf[0]});
      end
      $display("test query done");
      host.wbuf[0] = 8'h00;
      host.xfer(8'h55, 1, 0, 1'b0);
      check("unknown nack", 24'h1, {23'h0, host.nack_seen});
      host.build(1'b0);
      host.send_block(0, 32, 1'b0);
      check("block refused", 24'h1, {23'h0, host.nack_seen});
      $display("test refusal done");
      wr_mode(8'h01);
      check("upload on", 24'h1, {23'h0, upload_active});
      rd(CMD_STATUS, 2, 24'h0000);
      blink_period(per);
      check("blink period", 24'(BLINK), 24'(per));
      host.send_block(0, 32, 1'b0);
      rd(CMD_STATUS, 2, 24'h0002);
      host.send_block(1, 31, 1'b0);
      check("short block nack", 24'h1, {23'h0, host.nack_seen});
      host.send_block(1, 32, 1'b1);
      check("bad pec nack", 24'h1, {23'h0, host.nack_seen});
      host.send_block(1, 32, 1'b0);
      rd(CMD_STATUS, 2, 24'h0001);
      rd(CMD_REV, 4, 24'h000003);
      wr_mode(8'h00);
      check("commit", 24'h1, 24'(n_commit));
      check("upload off", 24'h0, {23'h0, upload_active});
      check("fw rev", 24'h851234, fw_rev);
      rd(CMD_REV, 4, 24'h123403);
      check("rev major", 24'h85, {16'h0, host.rbuf[3]});
      $display("test upload done");
      host.build(1'b1);
      wr_mode(8'h01);
      rd(CMD_STATUS, 2, 24'h0000);
      host.send_block(0, 32, 1'b0);
      host.send_block(1, 32, 1'b0);
      rd(CMD_STATUS, 2, 24'h0004);
      check("safe mode", 24'h1, {23'h0, safe_mode});
      wr_mode(8'h00);
      check("stay upload", 24'h1, {23'h0, upload_active});
      check("no commit", 24'h1, 24'(n_commit));
      check("rev kept", 24'h851234, fw_rev);
      wr_mode(8'h01);
      rd(CMD_STATUS, 2, 24'h0000);
      host.build(1'b0);
      host.send_block(0, 32, 1'b0);
      host.send_block(1, 32, 1'b0);
      wr_mode(8'h00);
      check("recovered", 24'h0, {22'h0, upload_active, safe_mode});
      main_ok = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("safe on bad main", 24'h1, {23'h0, safe_mode});
      $display("test corrupt image done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
